// file: pkg/ccss_pkg.sv
/*
  Constants for the control signal source selector: register map, reset values,
  temperature maxima, source codes and source flag positions.
  Assumes a 32-bit classic Wishbone slave with byte addresses.
*/
package ccss_pkg;

  localparam int unsigned CODE_W = 10;
  localparam int unsigned TEMP_W = 8;
  localparam int unsigned VAL_W  = 16;
  localparam int unsigned ADR_W  = 8;

  // Register byte offsets
  localparam logic [ADR_W-1:0] OFS_SINK_MARGIN   = 8'h00;
  localparam logic [ADR_W-1:0] OFS_INSIDE_MARGIN = 8'h04;
  localparam logic [ADR_W-1:0] OFS_SETTING_FREQ  = 8'h08;
  localparam logic [ADR_W-1:0] OFS_FREQ_BAND     = 8'h0c;
  localparam logic [ADR_W-1:0] OFS_PCT_BAND      = 8'h10;
  localparam logic [ADR_W-1:0] OFS_MOTOR_LIMIT   = 8'h14;
  localparam logic [ADR_W-1:0] OFS_MODE          = 8'h18;
  localparam logic [ADR_W-1:0] OFS_WARN_MASK     = 8'h1c;
  localparam logic [ADR_W-1:0] OFS_SRC_STATUS    = 8'h20;
  localparam logic [ADR_W-1:0] OFS_CONS_STATUS   = 8'h24;
  localparam logic [ADR_W-1:0] OFS_TEMP_STATUS   = 8'h28;
  localparam logic [ADR_W-1:0] OFS_CODE_BASE     = 8'h40;

  // Mode register fields
  localparam int unsigned MODE_MTEMP_LSB = 0;
  localparam int unsigned MODE_MTEMP_W   = 2;
  localparam int unsigned MODE_MPS_BIT   = 2;
  localparam int unsigned MODE_MAINS_BIT = 3;
  localparam int unsigned MODE_W         = 4;

  // Reset values
  localparam logic [TEMP_W-1:0] RST_SINK_MARGIN   = 8'h05;
  localparam logic [TEMP_W-1:0] RST_INSIDE_MARGIN = 8'h05;
  localparam logic [VAL_W-1:0]  RST_SETTING_FREQ  = 16'h0000;
  localparam logic [VAL_W-1:0]  RST_FREQ_BAND     = 16'h0000;
  localparam logic [VAL_W-1:0]  RST_PCT_BAND      = 16'h0000;
  localparam logic [TEMP_W-1:0] RST_MOTOR_LIMIT   = 8'h8c;
  localparam logic [MODE_W-1:0] RST_MODE          = 4'h0;
  localparam logic [31:0]       RST_WARN_MASK     = 32'h0000_ffff;
  localparam logic [CODE_W-1:0] RST_CODE          = 10'h000;

  // Fixed temperature maxima in degrees Celsius
  localparam logic [TEMP_W-1:0] SINK_MAX_C   = 8'h50;
  localparam logic [TEMP_W-1:0] INSIDE_MAX_C = 8'h41;

  // Motor temperature modes
  typedef enum logic [1:0] {
    CCSS_MT_OFF   = 2'b00,
    CCSS_MT_WARN  = 2'b01,
    CCSS_MT_LATCH = 2'b10,
    CCSS_MT_RSVD  = 2'b11
  } ccss_mtemp_e;

  // Source flag positions
  localparam int unsigned S_TIMER1     = 0;
  localparam int unsigned S_TIMER2     = 1;
  localparam int unsigned S_FREQ_REACH = 2;
  localparam int unsigned S_SET_FREQ   = 3;
  localparam int unsigned S_OVERLOAD   = 4;
  localparam int unsigned S_SINK_WARN  = 5;
  localparam int unsigned S_IN_WARN    = 6;
  localparam int unsigned S_MOTOR_WARN = 7;
  localparam int unsigned S_GEN_WARN   = 8;
  localparam int unsigned S_OVER_TEMP  = 9;
  localparam int unsigned S_CMP1       = 10;
  localparam int unsigned S_CMP2       = 11;
  localparam int unsigned S_DIG1       = 12;
  localparam int unsigned S_DIG2       = 13;
  localparam int unsigned S_DIG3       = 14;
  localparam int unsigned S_PCT_REACH  = 15;
  localparam int unsigned S_MAINS      = 16;
  localparam int unsigned S_MPS        = 17;
  localparam int unsigned S_LOGIC1     = 18;
  localparam int unsigned S_LOGIC2     = 19;
  localparam int unsigned SRC_W        = 20;

  // Source codes
  localparam logic [CODE_W-1:0] C_TIMER1     = 10'h09e;
  localparam logic [CODE_W-1:0] C_TIMER2     = 10'h09f;
  localparam logic [CODE_W-1:0] C_FREQ_REACH = 10'h0a3;
  localparam logic [CODE_W-1:0] C_SET_FREQ   = 10'h0a4;
  localparam logic [CODE_W-1:0] C_OVERLOAD   = 10'h0a5;
  localparam logic [CODE_W-1:0] C_SINK_WARN  = 10'h0a6;
  localparam logic [CODE_W-1:0] C_IN_WARN    = 10'h0a7;
  localparam logic [CODE_W-1:0] C_MOTOR_WARN = 10'h0a8;
  localparam logic [CODE_W-1:0] C_GEN_WARN   = 10'h0a9;
  localparam logic [CODE_W-1:0] C_OVER_TEMP  = 10'h0aa;
  localparam logic [CODE_W-1:0] C_CMP1       = 10'h0ab;
  localparam logic [CODE_W-1:0] C_CMP1_N     = 10'h0ac;
  localparam logic [CODE_W-1:0] C_CMP2       = 10'h0ad;
  localparam logic [CODE_W-1:0] C_CMP2_N     = 10'h0ae;
  localparam logic [CODE_W-1:0] C_DIG1       = 10'h0af;
  localparam logic [CODE_W-1:0] C_DIG2       = 10'h0b0;
  localparam logic [CODE_W-1:0] C_DIG3       = 10'h0b1;
  localparam logic [CODE_W-1:0] C_PCT_REACH  = 10'h0b2;
  localparam logic [CODE_W-1:0] C_MAINS      = 10'h0b3;
  localparam logic [CODE_W-1:0] C_MPS        = 10'h0b4;
  localparam logic [CODE_W-1:0] C_LOGIC1     = 10'h0dc;
  localparam logic [CODE_W-1:0] C_LOGIC1_N   = 10'h0dd;
  localparam logic [CODE_W-1:0] C_LOGIC2     = 10'h0de;
  localparam logic [CODE_W-1:0] C_LOGIC2_N   = 10'h0df;

endpackage

// file: pkg/ccss_sel_if.sv
/*
  Carrier between the selector top and its per-consumer decoder.
  Assumes both ends run on the same clock; the decoder is combinational.
*/
`timescale 1ns/10ps
interface ccss_sel_if
  import ccss_pkg::*;
#(
  parameter int unsigned NCON = 8
);
  logic [SRC_W-1:0]  src;
  logic [CODE_W-1:0] code [NCON];
  logic [NCON-1:0]   hit;

  modport top (output src, output code, input hit);
  modport sel (input src, input code, output hit);
endinterface

// file: rtl/ccss_decode.sv
/*
  Per-consumer source code decoder: maps each stored code onto a source flag.
  Assumes registered source flags and codes arrive on the carrier.
*/
`timescale 1ns/10ps
module ccss_decode
  import ccss_pkg::*;
#(
  parameter int unsigned NCON = 8
)(
  ccss_sel_if.sel bus
);

  for (genvar g = 0; g < NCON; g++)
  begin : g_con
    always_comb
    begin
      unique case (bus.code[g])
        C_TIMER1:     bus.hit[g] = bus.src[S_TIMER1];
        C_TIMER2:     bus.hit[g] = bus.src[S_TIMER2];
        C_FREQ_REACH: bus.hit[g] = bus.src[S_FREQ_REACH];
        C_SET_FREQ:   bus.hit[g] = bus.src[S_SET_FREQ];
        C_OVERLOAD:   bus.hit[g] = bus.src[S_OVERLOAD];
        C_SINK_WARN:  bus.hit[g] = bus.src[S_SINK_WARN];
        C_IN_WARN:    bus.hit[g] = bus.src[S_IN_WARN];
        C_MOTOR_WARN: bus.hit[g] = bus.src[S_MOTOR_WARN];
        C_GEN_WARN:   bus.hit[g] = bus.src[S_GEN_WARN];
        C_OVER_TEMP:  bus.hit[g] = bus.src[S_OVER_TEMP];
        C_CMP1:       bus.hit[g] = bus.src[S_CMP1];
        C_CMP1_N:     bus.hit[g] = ~bus.src[S_CMP1];
        C_CMP2:       bus.hit[g] = bus.src[S_CMP2];
        C_CMP2_N:     bus.hit[g] = ~bus.src[S_CMP2];
        C_DIG1:       bus.hit[g] = bus.src[S_DIG1];
        C_DIG2:       bus.hit[g] = bus.src[S_DIG2];
        C_DIG3:       bus.hit[g] = bus.src[S_DIG3];
        C_PCT_REACH:  bus.hit[g] = bus.src[S_PCT_REACH];
        C_MAINS:      bus.hit[g] = bus.src[S_MAINS];
        C_MPS:        bus.hit[g] = bus.src[S_MPS];
        C_LOGIC1:     bus.hit[g] = bus.src[S_LOGIC1];
        C_LOGIC1_N:   bus.hit[g] = ~bus.src[S_LOGIC1];
        C_LOGIC2:     bus.hit[g] = bus.src[S_LOGIC2];
        C_LOGIC2_N:   bus.hit[g] = ~bus.src[S_LOGIC2];
        // Unknown codes, including the unused gaps, give a quiet low
        default:      bus.hit[g] = 1'b0;
      endcase
    end
  end

endmodule

// file: rtl/ccss_top.sv
/*
  Control signal source selector: derives boolean sources from drive status
  and routes a chosen source onto each consumer input, set over Wishbone.
  Assumes all status inputs come from logic on clk_i; one clock, sync reset.
*/
// Implementation choices: register access over Wishbone and the register addresses.
// What this block does
// - Codes 158/159 give timer one/two outputs
// - Code 163: actual frequency reached reference
// - Code 164: setting frequency at most actual
// - Code 165: inverter overload reported
// - Code 166: heat sink at max minus margin
// - Code 167: inside temp at max minus margin
// - Code 168: motor thermistor warning per mode
// - Code 169: masked warnings show critical point
// - Code 170: any over-temperature limit exceeded
// - Codes 171/173 give comparator one/two results
// - Codes 172/174 invert comparator results
// - Codes 175-177 mirror three digital output signals
// - Code 178: actual percentage reached reference
// - Code 179: mains failure with regulation enabled
// - Code 180: motor protection switch tripped
// - Codes 220/222 give logic module outputs
// - Codes 221/223 invert logic module outputs
`timescale 1ns/10ps
module ccss_top
  import ccss_pkg::*;
#(
  parameter int unsigned NCON = 8
)(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // Wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [ADR_W-1:0]        wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // Drive status
  input  wire logic                    timer_one_i,
  input  wire logic                    timer_two_i,
  input  wire logic [VAL_W-1:0]        actual_frequency_i,
  input  wire logic [VAL_W-1:0]        reference_frequency_i,
  input  wire logic [VAL_W-1:0]        actual_percentage_i,
  input  wire logic [VAL_W-1:0]        reference_percentage_i,
  input  wire logic                    overload_i,
  input  wire logic [TEMP_W-1:0]       heat_sink_temperature_i,
  input  wire logic [TEMP_W-1:0]       inside_temperature_i,
  input  wire logic [TEMP_W-1:0]       motor_thermistor_temperature_i,
  input  wire logic [31:0]             warnings_i,
  input  wire logic                    comparator_one_i,
  input  wire logic                    comparator_two_i,
  input  wire logic                    digital_output_one_i,
  input  wire logic                    multi_function_output_one_i,
  input  wire logic                    digital_output_three_i,
  input  wire logic                    mains_failure_i,
  input  wire logic                    motor_protection_trip_i,
  input  wire logic                    logic_module_one_i,
  input  wire logic                    logic_module_two_i,
  // Consumer inputs
  output logic      [NCON-1:0]         consumer_o
);

  logic [TEMP_W-1:0]  sink_margin_q;
  logic [TEMP_W-1:0]  inside_margin_q;
  logic [VAL_W-1:0]   setting_freq_q;
  logic [VAL_W-1:0]   freq_band_q;
  logic [VAL_W-1:0]   pct_band_q;
  logic [TEMP_W-1:0]  motor_limit_q;
  logic [MODE_W-1:0]  mode_q;
  logic [31:0]        warn_mask_q;
  logic [CODE_W-1:0]  code_q [NCON];
  logic [SRC_W-1:0]   src_q;
  logic [SRC_W-1:0]   src_d;
  logic               motor_latch_q;
  logic               ack_q;
  logic [31:0]        dat_q;
  logic [NCON-1:0]    consumer_q;
  logic               wr_en;
  logic               rd_en;
  logic [31:0]        wmask;
  logic [31:0]        rdata;
  logic [TEMP_W-1:0]  sink_limit;
  logic [TEMP_W-1:0]  inside_limit;
  logic [VAL_W-1:0]   freq_diff;
  logic [VAL_W-1:0]   pct_diff;
  logic               motor_hot;
  ccss_mtemp_e        mtemp_mode;

  ccss_sel_if #(.NCON(NCON)) sel_bus ();

  ccss_decode #(
    .NCON (NCON)
  ) u_decode (
    .bus  (sel_bus.sel)
  );

  // Bus strobes; the ack register blocks a second access in the ack cycle
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;
  assign rd_en = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_q;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sink_margin_q   <= RST_SINK_MARGIN;
      inside_margin_q <= RST_INSIDE_MARGIN;
      setting_freq_q  <= RST_SETTING_FREQ;
      freq_band_q     <= RST_FREQ_BAND;
      pct_band_q      <= RST_PCT_BAND;
      motor_limit_q   <= RST_MOTOR_LIMIT;
      mode_q          <= RST_MODE;
      warn_mask_q     <= RST_WARN_MASK;
    end
    else if (wr_en)
    begin
      unique case (wb_adr_i)
        OFS_SINK_MARGIN:
          sink_margin_q <= (sink_margin_q & ~wmask[TEMP_W-1:0])
                         | (wb_dat_i[TEMP_W-1:0] & wmask[TEMP_W-1:0]);
        OFS_INSIDE_MARGIN:
          inside_margin_q <= (inside_margin_q & ~wmask[TEMP_W-1:0])
                           | (wb_dat_i[TEMP_W-1:0] & wmask[TEMP_W-1:0]);
        OFS_SETTING_FREQ:
          setting_freq_q <= (setting_freq_q & ~wmask[VAL_W-1:0])
                          | (wb_dat_i[VAL_W-1:0] & wmask[VAL_W-1:0]);
        OFS_FREQ_BAND:
          freq_band_q <= (freq_band_q & ~wmask[VAL_W-1:0])
                       | (wb_dat_i[VAL_W-1:0] & wmask[VAL_W-1:0]);
        OFS_PCT_BAND:
          pct_band_q <= (pct_band_q & ~wmask[VAL_W-1:0])
                      | (wb_dat_i[VAL_W-1:0] & wmask[VAL_W-1:0]);
        OFS_MOTOR_LIMIT:
          motor_limit_q <= (motor_limit_q & ~wmask[TEMP_W-1:0])
                         | (wb_dat_i[TEMP_W-1:0] & wmask[TEMP_W-1:0]);
        OFS_MODE:
          mode_q <= (mode_q & ~wmask[MODE_W-1:0])
                  | (wb_dat_i[MODE_W-1:0] & wmask[MODE_W-1:0]);
        OFS_WARN_MASK:
          warn_mask_q <= (warn_mask_q & ~wmask) | (wb_dat_i & wmask);
        default:
        begin
        end
      endcase
    end
  end

  // Consumer code table, one word per consumer
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < NCON; i++)
    begin
      if (rst_i)
      begin
        code_q[i] <= RST_CODE;
      end
      else if (wr_en && wb_adr_i == OFS_CODE_BASE + ADR_W'(4 * i))
      begin
        code_q[i] <= (code_q[i] & ~wmask[CODE_W-1:0])
                   | (wb_dat_i[CODE_W-1:0] & wmask[CODE_W-1:0]);
      end
    end
  end

  // Warning thresholds clamp at zero if the margin exceeds the maximum
  assign sink_limit   = (sink_margin_q >= SINK_MAX_C) ? '0 : SINK_MAX_C - sink_margin_q;
  assign inside_limit = (inside_margin_q >= INSIDE_MAX_C) ? '0 : INSIDE_MAX_C - inside_margin_q;
  assign freq_diff    = (actual_frequency_i >= reference_frequency_i)
                      ? actual_frequency_i - reference_frequency_i
                      : reference_frequency_i - actual_frequency_i;
  assign pct_diff     = (actual_percentage_i >= reference_percentage_i)
                      ? actual_percentage_i - reference_percentage_i
                      : reference_percentage_i - actual_percentage_i;
  assign motor_hot    = motor_thermistor_temperature_i >= motor_limit_q;
  assign mtemp_mode   = ccss_mtemp_e'(mode_q[MODE_MTEMP_LSB +: MODE_MTEMP_W]);

  // Latched mode holds the warning until reset or until the motor temperature mode field leaves latched
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      motor_latch_q <= 1'b0;
    end
    else if (mtemp_mode != CCSS_MT_LATCH)
    begin
      motor_latch_q <= 1'b0;
    end
    else if (motor_hot)
    begin
      motor_latch_q <= 1'b1;
    end
  end

  always_comb
  begin
    src_d               = '0;
    src_d[S_TIMER1]     = timer_one_i;
    src_d[S_TIMER2]     = timer_two_i;
    src_d[S_FREQ_REACH] = freq_diff <= freq_band_q;
    src_d[S_SET_FREQ]   = setting_freq_q <= actual_frequency_i;
    src_d[S_OVERLOAD]   = overload_i;
    src_d[S_SINK_WARN]  = heat_sink_temperature_i >= sink_limit;
    src_d[S_IN_WARN]    = inside_temperature_i >= inside_limit;
    unique case (mtemp_mode)
      CCSS_MT_WARN:  src_d[S_MOTOR_WARN] = motor_hot;
      CCSS_MT_LATCH: src_d[S_MOTOR_WARN] = motor_hot | motor_latch_q;
      default:       src_d[S_MOTOR_WARN] = 1'b0;
    endcase
    src_d[S_GEN_WARN]   = |(warnings_i & warn_mask_q);
    src_d[S_OVER_TEMP]  = (heat_sink_temperature_i > sink_limit)
                        | (inside_temperature_i > inside_limit)
                        | (motor_thermistor_temperature_i > motor_limit_q);
    src_d[S_CMP1]       = comparator_one_i;
    src_d[S_CMP2]       = comparator_two_i;
    src_d[S_DIG1]       = digital_output_one_i;
    src_d[S_DIG2]       = multi_function_output_one_i;
    src_d[S_DIG3]       = digital_output_three_i;
    src_d[S_PCT_REACH]  = pct_diff <= pct_band_q;
    src_d[S_MAINS]      = mains_failure_i & mode_q[MODE_MAINS_BIT];
    src_d[S_MPS]        = motor_protection_trip_i & mode_q[MODE_MPS_BIT];
    src_d[S_LOGIC1]     = logic_module_one_i;
    src_d[S_LOGIC2]     = logic_module_two_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      src_q <= '0;
    end
    else
    begin
      src_q <= src_d;
    end
  end

  assign sel_bus.src  = src_q;
  assign sel_bus.code = code_q;

  // Registered consumer outputs; two cycles from status input to output
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      consumer_q <= '0;
    end
    else
    begin
      consumer_q <= sel_bus.hit;
    end
  end

  // Read mux; unmapped addresses read zero and are still acknowledged
  always_comb
  begin
    rdata = '0;
    unique case (wb_adr_i)
      OFS_SINK_MARGIN:   rdata[TEMP_W-1:0] = sink_margin_q;
      OFS_INSIDE_MARGIN: rdata[TEMP_W-1:0] = inside_margin_q;
      OFS_SETTING_FREQ:  rdata[VAL_W-1:0]  = setting_freq_q;
      OFS_FREQ_BAND:     rdata[VAL_W-1:0]  = freq_band_q;
      OFS_PCT_BAND:      rdata[VAL_W-1:0]  = pct_band_q;
      OFS_MOTOR_LIMIT:   rdata[TEMP_W-1:0] = motor_limit_q;
      OFS_MODE:          rdata[MODE_W-1:0] = mode_q;
      OFS_WARN_MASK:     rdata             = warn_mask_q;
      OFS_SRC_STATUS:    rdata[SRC_W-1:0]  = src_q;
      OFS_CONS_STATUS:   rdata[NCON-1:0]   = consumer_q;
      OFS_TEMP_STATUS:   rdata[2*TEMP_W-1:0] = {inside_limit, sink_limit};
      default:
      begin
        for (int i = 0; i < NCON; i++)
        begin
          if (wb_adr_i == OFS_CODE_BASE + ADR_W'(4 * i))
          begin
            rdata[CODE_W-1:0] = code_q[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dat_q <= '0;
    end
    else if (rd_en)
    begin
      dat_q <= rdata;
    end
  end

  assign wb_ack_o   = ack_q;
  assign wb_dat_o   = dat_q;
  assign consumer_o = consumer_q;

endmodule

// file: verification/ccss_checker.sv
/* Checker for ccss_top: bus handshake and routing onto consumer 0.
   Assumes a bind to ccss_top; the code of consumer 0 is mirrored from bus writes. */
`timescale 1ns/10ps
module ccss_checker
  import ccss_pkg::*;
#(
  parameter int unsigned NCON = 8
)(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [ADR_W-1:0]  wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic              wb_ack_o,
  input wire logic              timer_one_i,
  input wire logic              overload_i,
  input wire logic              comparator_one_i,
  input wire logic              multi_function_output_one_i,
  input wire logic              logic_module_one_i,
  input wire logic [NCON-1:0]   consumer_o
);
  logic [CODE_W-1:0] c0_q;
  logic [1:0]        age_q;
  logic              wr0;
  logic              ok;
  assign wr0 = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == OFS_CODE_BASE;
  // Routing is judged only once the code has settled, as it takes two edges to apply
  assign ok = age_q == 2'd3;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      c0_q <= RST_CODE;
    else if (wr0)
    begin
      if (wb_sel_i[0])
        c0_q[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        c0_q[9:8] <= wb_dat_i[9:8];
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i || wr0)
      age_q <= 2'd0;
    else if (age_q != 2'd3)
      age_q <= age_q + 2'd1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  property p_route(logic [CODE_W-1:0] c, logic inv, logic src);
    ok && c0_q == c |-> consumer_o[0] == ($past(src, 2) ^ inv);
  endproperty
  a_ack_answer: assert property (s_req |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("ack without request");
  a_timer_route: assert property (p_route(C_TIMER1, 1'b0, timer_one_i))
    else $error("timer source wrong");
  a_overload_route: assert property (p_route(C_OVERLOAD, 1'b0, overload_i))
    else $error("overload source wrong");
  a_cmp_invert: assert property (p_route(C_CMP1_N, 1'b1, comparator_one_i))
    else $error("inverted comparator wrong");
  a_mirror_route: assert property (p_route(C_DIG2, 1'b0, multi_function_output_one_i))
    else $error("output mirror wrong");
  a_logic_invert: assert property (p_route(C_LOGIC1_N, 1'b1, logic_module_one_i))
    else $error("inverted logic module wrong");
  a_unknown_low: assert property (ok && c0_q == 10'h3ff |-> !consumer_o[0])
    else $error("unknown code not low");
endmodule
bind ccss_top ccss_checker #(.NCON(NCON)) u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .timer_one_i, .overload_i,
  .comparator_one_i, .multi_function_output_one_i, .logic_module_one_i, .consumer_o);

// file: verification/tb_top.sv
/* Self-checking bench for ccss_top.
   Assumes the checker is bound by its own file; bench drives all ports itself. */
`timescale 1ns/10ps
module tb_top
  import ccss_pkg::*;
;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = '0, hs = '0, ins = '0, mt = '0, consumer_o;
  logic [31:0] wdat = '0, wn = '0, rd, wb_dat_o;
  logic [15:0] af = '0, rf = '0, ap = '0, rp = '0;
  logic [11:0] b = '0;
  logic [3:0]  sel = 4'hf, lanes = 4'hf;
  logic        wb_ack_o;
  int          n_fail = 0, cmp_count = 0;
  localparam logic [9:0] CD [14] = '{C_TIMER1, C_TIMER2, C_OVERLOAD, C_CMP1, C_CMP1_N,
    C_CMP2, C_CMP2_N, C_DIG1, C_DIG2, C_DIG3, C_LOGIC1, C_LOGIC1_N, C_LOGIC2, C_LOGIC2_N};
  localparam int BI [14] = '{0, 1, 2, 3, 3, 4, 4, 5, 6, 7, 8, 8, 9, 9};
  localparam int IV [14] = '{0, 0, 0, 0, 1, 0, 1, 0, 0, 0, 0, 1, 0, 1};
  ccss_top u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o, .wb_ack_o,
    .timer_one_i(b[0]), .timer_two_i(b[1]), .overload_i(b[2]), .comparator_one_i(b[3]),
    .comparator_two_i(b[4]), .digital_output_one_i(b[5]),
    .multi_function_output_one_i(b[6]), .digital_output_three_i(b[7]),
    .logic_module_one_i(b[8]), .logic_module_two_i(b[9]), .mains_failure_i(b[10]),
    .motor_protection_trip_i(b[11]), .actual_frequency_i(af), .reference_frequency_i(rf),
    .actual_percentage_i(ap), .reference_percentage_i(rp), .heat_sink_temperature_i(hs),
    .inside_temperature_i(ins), .motor_thermistor_temperature_i(mt), .warnings_i(wn),
    .consumer_o);
  always #10 clk_i = ~clk_i;
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Ack and read data are taken at the rising edge, before the design updates them
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= lanes;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1)
    begin
      n_fail++;
      stop_test;
    end
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task code(input int i, input logic [9:0] c);
    wb(1'b1, OFS_CODE_BASE + 8'(4 * i), {22'h0, c});
  endtask
  task sc(input logic [7:0] m, input logic [7:0] e);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk("consumer", {24'h0, consumer_o & m}, {24'h0, e});
  endtask
  task tp(input logic [7:0] h, input logic [7:0] i, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_i);
    hs <= h;
    ins <= i;
    mt <= m;
    sc(8'h1e, e);
  endtask
  task fq(input logic [15:0] a, r, p, q, input logic [7:0] e);
    @(posedge clk_i);
    af <= a;
    rf <= r;
    ap <= p;
    rp <= q;
    sc(8'he0, e);
  endtask
  task t_reset;
    chk("consumer", {24'h0, consumer_o}, 32'h0);
    wb(1'b0, OFS_SINK_MARGIN, 32'h0);
    chk("sink margin", rd, 32'h5);
    wb(1'b0, OFS_MOTOR_LIMIT, 32'h0);
    chk("motor limit", rd, 32'h8c);
    lanes = 4'he;
    wb(1'b1, OFS_MOTOR_LIMIT, 32'hff);
    lanes = 4'hf;
    wb(1'b0, OFS_MOTOR_LIMIT, 32'h0);
    chk("masked lane", rd, 32'h8c);
    wb(1'b0, OFS_WARN_MASK, 32'h0);
    chk("warn mask", rd, 32'hffff);
    wb(1'b0, OFS_CODE_BASE, 32'h0);
    chk("code", rd, 32'h0);
    wb(1'b0, 8'hfc, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("reset test done");
  endtask
  task t_route;
    for (int k = 0; k < 14; k++)
    begin
      code(0, CD[k]);
      for (int v = 0; v < 2; v++)
      begin
        @(posedge clk_i);
        b <= 12'(v) << BI[k];
        sc(8'h01, 8'(v ^ IV[k]));
      end
    end
    code(0, 10'h3ff);
    @(posedge clk_i);
    b <= 12'h3ff;
    sc(8'h01, 8'h00);
    $display("route test done");
  endtask
  task t_temp;
    code(1, C_SINK_WARN);
    code(2, C_OVER_TEMP);
    code(3, C_IN_WARN);
    code(4, C_MOTOR_WARN);
    tp(74, 59, 0, 8'h00);
    tp(75, 0, 0, 8'h02);
    tp(76, 0, 0, 8'h06);
    tp(0, 60, 0, 8'h08);
    tp(0, 61, 0, 8'h0c);
    tp(0, 0, 140, 8'h00);
    wb(1'b1, OFS_MODE, 32'h1);
    tp(0, 0, 140, 8'h10);
    tp(0, 0, 139, 8'h00);
    wb(1'b1, OFS_MODE, 32'h2);
    tp(0, 0, 140, 8'h10);
    tp(0, 0, 0, 8'h10);
    wb(1'b1, OFS_MODE, 32'h0);
    tp(0, 0, 0, 8'h00);
    tp(0, 0, 141, 8'h04);
    wb(1'b1, OFS_SINK_MARGIN, 32'ha);
    wb(1'b1, OFS_INSIDE_MARGIN, 32'ha);
    tp(70, 55, 0, 8'h0a);
    wb(1'b0, OFS_TEMP_STATUS, 32'h0);
    chk("thresholds", rd, 32'h3746);
    $display("temperature test done");
  endtask
  task t_freq;
    code(5, C_FREQ_REACH);
    code(6, C_SET_FREQ);
    code(7, C_PCT_REACH);
    wb(1'b1, OFS_SETTING_FREQ, 32'h64);
    fq(99, 99, 7, 7, 8'ha0);
    fq(100, 101, 7, 8, 8'h40);
    wb(1'b1, OFS_FREQ_BAND, 32'h1);
    wb(1'b1, OFS_PCT_BAND, 32'h1);
    fq(100, 101, 7, 8, 8'he0);
    fq(102, 100, 9, 7, 8'h40);
    $display("frequency test done");
  endtask
  task t_ctrl;
    code(5, C_GEN_WARN);
    code(6, C_MAINS);
    code(7, C_MPS);
    @(posedge clk_i);
    wn <= 32'h1_0000;
    b <= 12'hc00;
    sc(8'he0, 8'h00);
    wb(1'b1, OFS_MODE, 32'hc);
    sc(8'he0, 8'hc0);
    @(posedge clk_i);
    wn <= 32'h1;
    sc(8'he0, 8'he0);
    wb(1'b1, OFS_WARN_MASK, 32'h1_0000);
    sc(8'he0, 8'hc0);
    $display("control test done");
  endtask
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_route;
    t_temp;
    t_freq;
    t_ctrl;
    stop_test;
  end
endmodule
